// *** hdl/vpg_regs.sv ***
// Register slice of the video encoder: line-16 label bytes, carrier phase,
// chroma gains, real-time control follow bits, black and blanking levels.
// Assumes a synchronous byte register port and a line timing source outside.
//
// Our own choice: the strobed register port.
`timescale 1ns/1ps
`default_nettype none

module vpg_regs
  import vpg_pkg::*;
(
  input wire logic clock, // 100 MHz clock
  input wire logic nrst, // Asynchronous reset, active low
  input wire vpg_pkg::vpg_bus_type bus, // Register request
  output logic [vpg_pkg::DATA_W-1:0] rdata, // Read data, cycle after read
  input wire logic labelWindow, // High over the line-16 label slot
  input wire logic labelBitTick, // One pulse per label bit
  output logic labelBit, // Serial label bit
  output logic labelBitValid, // Pulse with each label bit
  output logic labelInsertOn, // Label insertion enabled
  input wire logic hsync, // Horizontal sync pulse
  output logic [vpg_pkg::DATA_W-1:0] carrierPhaseCode, // Phase code to carrier
  output logic [vpg_pkg::PHASE_CDEG_W-1:0] carrierPhaseCdeg, // Phase in centi-degrees
  output logic carrierPhaseLoad, // Load phase into oscillator
  input wire vpg_pkg::vpg_chroma_type chromaIn, // Colour-difference samples
  output vpg_pkg::vpg_mod_type chromaOut, // Scaled samples to modulator
  output logic [vpg_pkg::GAIN_W-1:0] blueDiffGainCode, // Nine-bit U gain
  output logic [vpg_pkg::GAIN_W-1:0] redDiffGainCode, // Nine-bit V gain
  input wire vpg_pkg::vpg_rtc_type rtcIn, // Decoded real-time control bits
  output logic fieldParity, // Field parity taken from control input
  output logic fieldParityValid, // Field parity being followed
  output logic carrierPhaseReset, // Phase reset pulse from control input
  input wire logic whiteToSync143, // 1 selects the 143 IRE scale
  output logic [vpg_pkg::LEVEL_W-1:0] blackLevelCode, // Black level code
  output logic [vpg_pkg::LEVEL_W-1:0] blankingLevelCode, // Blanking level code
  output logic [vpg_pkg::MILLI_W-1:0] blackLevelMilli, // Black level, milli-IRE
  output logic [vpg_pkg::MILLI_W-1:0] blankingLevelMilli // Blanking level, milli-IRE
);
  import vpg_pkg::*;

  logic [DATA_W-1:0] labelByte_q [LABEL_BYTES];
  logic programLabelInsertOn_q;
  logic [DATA_W-1:0] carrierPhaseCode_q;
  logic [DATA_W-1:0] blueDiffGain_q;
  logic [DATA_W-1:0] redDiffGain_q;
  logic blueDiffGainTop_q;
  logic redDiffGainTop_q;
  logic fieldParityFollowOn_q;
  logic carrierPhaseResetFollowOn_q;
  logic [LEVEL_W-1:0] blackLevelCode_q;
  logic [LEVEL_W-1:0] blankingLevelCode_q;
  logic [DATA_W-1:0] rdata_q;
  logic [DATA_W-1:0] rdata_d;
  logic [LABEL_IDX_W-1:0] labelIdx_q;
  logic labelBit_q;
  logic labelBitValid_q;
  logic carrierPhaseLoad_q;
  logic [PHASE_CDEG_W-1:0] carrierPhaseCdeg_q;
  vpg_mod_type chromaOut_q;
  logic fieldParity_q;
  logic carrierPhaseReset_q;
  logic [MILLI_W-1:0] blackLevelMilli_q;
  logic [MILLI_W-1:0] blankingLevelMilli_q;
  logic [GAIN_W-1:0] blueGainFull;
  logic [GAIN_W-1:0] redGainFull;

  function automatic logic wr_hit(input vpg_bus_type b, input logic [ADDR_W-1:0] ofs);
    wr_hit = b.wr && (b.addr == ofs);
  endfunction

  // Milli-IRE level from a six-bit code, a slope and an offset
  function automatic logic [MILLI_W-1:0] level_milli(
    input logic [LEVEL_W-1:0] code,
    input logic [MILLI_W-1:0] slope,
    input logic [MILLI_W-1:0] offset
  );
    logic [MILLI_W+LEVEL_W-1:0] prod;
    prod = {{MILLI_W{1'b0}}, code} * {{LEVEL_W{1'b0}}, slope};
    level_milli = prod[MILLI_W-1:0] + offset;
  endfunction

  // Signed product of a chroma sample and a nine-bit gain code
  function automatic logic signed [PROD_W-1:0] scale(
    input logic signed [CHROMA_W-1:0] sample,
    input logic [GAIN_W-1:0] gain
  );
    logic signed [PROD_W-1:0] s;
    logic signed [PROD_W-1:0] g;
    s = PROD_W'(sample);
    g = PROD_W'($signed(gain));
    scale = s * g;
  endfunction

  assign blueGainFull = {blueDiffGainTop_q, blueDiffGain_q};
  assign redGainFull = {redDiffGainTop_q, redDiffGain_q};

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      for (int i = 0; i < LABEL_BYTES; i++)
      begin
        labelByte_q[i] <= RST_BYTE;
      end
    end
    else
    begin
      for (int i = 0; i < LABEL_BYTES; i++)
      begin
        if (wr_hit(bus, OFS_LABEL_A + ADDR_W'(i)))
        begin
          labelByte_q[i] <= bus.wdata;
        end
      end
    end
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      programLabelInsertOn_q <= 1'b0;
    end
    else if (wr_hit(bus, OFS_LABEL_CTRL))
    begin
      programLabelInsertOn_q <= bus.wdata[POS_INSERT_ON];
    end
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      carrierPhaseCode_q <= RST_BYTE;
    end
    else if (wr_hit(bus, OFS_CARRIER_PHASE))
    begin
      carrierPhaseCode_q <= bus.wdata;
    end
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      blueDiffGain_q <= RST_BYTE;
      redDiffGain_q <= RST_BYTE;
    end
    else
    begin
      if (wr_hit(bus, OFS_BLUE_GAIN))
      begin
        blueDiffGain_q <= bus.wdata;
      end
      if (wr_hit(bus, OFS_RED_GAIN))
      begin
        redDiffGain_q <= bus.wdata;
      end
    end
  end

  // blue top bit, parity follow and black level
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      blueDiffGainTop_q <= 1'b0;
      fieldParityFollowOn_q <= 1'b0;
      blackLevelCode_q <= RST_BLACK;
    end
    else if (wr_hit(bus, OFS_BLUE_TOP_BLACK))
    begin
      blueDiffGainTop_q <= bus.wdata[POS_GAIN_TOP];
      fieldParityFollowOn_q <= bus.wdata[POS_FOLLOW_ON];
      blackLevelCode_q <= bus.wdata[POS_LEVEL_HI:0];
    end
  end

  // red top bit, phase reset follow and blanking level
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      redDiffGainTop_q <= 1'b0;
      carrierPhaseResetFollowOn_q <= 1'b0;
      blankingLevelCode_q <= RST_BLANK;
    end
    else if (wr_hit(bus, OFS_RED_TOP_BLANK))
    begin
      redDiffGainTop_q <= bus.wdata[POS_GAIN_TOP];
      carrierPhaseResetFollowOn_q <= bus.wdata[POS_FOLLOW_ON];
      blankingLevelCode_q <= bus.wdata[POS_LEVEL_HI:0];
    end
  end

  // Read decode; unmapped addresses read zero
  always_comb
  begin
    rdata_d = '0;
    if (bus.rd)
    begin
      unique case (bus.addr)
        OFS_LABEL_CTRL: rdata_d[POS_INSERT_ON] = programLabelInsertOn_q;
        OFS_LABEL_A: rdata_d = labelByte_q[0];
        OFS_LABEL_B: rdata_d = labelByte_q[1];
        OFS_LABEL_C: rdata_d = labelByte_q[2];
        OFS_LABEL_D: rdata_d = labelByte_q[3];
        OFS_LABEL_E: rdata_d = labelByte_q[4];
        OFS_CARRIER_PHASE: rdata_d = carrierPhaseCode_q;
        OFS_BLUE_GAIN: rdata_d = blueDiffGain_q;
        OFS_RED_GAIN: rdata_d = redDiffGain_q;
        OFS_BLUE_TOP_BLACK: rdata_d = {blueDiffGainTop_q, fieldParityFollowOn_q, blackLevelCode_q};
        OFS_RED_TOP_BLANK:
          rdata_d = {redDiffGainTop_q, carrierPhaseResetFollowOn_q, blankingLevelCode_q};
        default: rdata_d = '0;
      endcase
    end
  end

  // Read data stands one cycle only
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      rdata_q <= '0;
    end
    else
    begin
      rdata_q <= rdata_d;
    end
  end

  // serialiser: bytes in order, LSB first, restarts each window
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      labelIdx_q <= '0;
      labelBit_q <= 1'b0;
      labelBitValid_q <= 1'b0;
    end
    else
    begin
      labelBitValid_q <= 1'b0;
      if (!labelWindow || !programLabelInsertOn_q)
      begin
        labelIdx_q <= '0;
        labelBit_q <= 1'b0;
      end
      else if (labelBitTick && (labelIdx_q < LABEL_IDX_W'(LABEL_BITS)))
      begin
        labelBit_q <= labelByte_q[labelIdx_q[LABEL_IDX_W-1:3]][labelIdx_q[2:0]];
        labelBitValid_q <= 1'b1;
        labelIdx_q <= labelIdx_q + 1'b1;
      end
    end
  end

  // phase load at sync, angle from the code
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      carrierPhaseLoad_q <= 1'b0;
      carrierPhaseCdeg_q <= '0;
    end
    else
    begin
      carrierPhaseLoad_q <= hsync;
      carrierPhaseCdeg_q <=
        PHASE_CDEG_W'(({16'h0000, carrierPhaseCode_q} * PHASE_FULL_CDEG) >> PHASE_STEP_SHIFT);
    end
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      chromaOut_q <= '0;
    end
    else
    begin
      chromaOut_q.u <= scale(chromaIn.cb, blueGainFull);
      chromaOut_q.v <= scale(chromaIn.cr, redGainFull);
      chromaOut_q.valid <= chromaIn.valid;
    end
  end

  // field parity follows control input only when enabled
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      fieldParity_q <= 1'b0;
    end
    else if (fieldParityFollowOn_q && rtcIn.strobe)
    begin
      fieldParity_q <= rtcIn.fieldParity;
    end
  end

  // phase reset pulse only when enabled
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      carrierPhaseReset_q <= 1'b0;
    end
    else
    begin
      carrierPhaseReset_q <= carrierPhaseResetFollowOn_q && rtcIn.strobe && rtcIn.phaseReset;
    end
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      blackLevelMilli_q <= '0;
      blankingLevelMilli_q <= '0;
    end
    else if (whiteToSync143)
    begin
      blackLevelMilli_q <= level_milli(blackLevelCode_q, SLOPE_143, BLACK_OFS_143);
      blankingLevelMilli_q <= level_milli(blankingLevelCode_q, SLOPE_143, BLANK_OFS_143);
    end
    else
    begin
      blackLevelMilli_q <= level_milli(blackLevelCode_q, SLOPE_140, BLACK_OFS_140);
      blankingLevelMilli_q <= level_milli(blankingLevelCode_q, SLOPE_140, BLANK_OFS_140);
    end
  end

  assign rdata = rdata_q;
  assign labelBit = labelBit_q;
  assign labelBitValid = labelBitValid_q;
  assign labelInsertOn = programLabelInsertOn_q;
  assign carrierPhaseCode = carrierPhaseCode_q;
  assign carrierPhaseCdeg = carrierPhaseCdeg_q;
  assign carrierPhaseLoad = carrierPhaseLoad_q;
  assign chromaOut = chromaOut_q;
  assign blueDiffGainCode = {blueDiffGainTop_q, blueDiffGain_q};
  assign redDiffGainCode = {redDiffGainTop_q, redDiffGain_q};
  assign fieldParity = fieldParity_q;
  assign fieldParityValid = fieldParityFollowOn_q;
  assign carrierPhaseReset = carrierPhaseReset_q;
  assign blackLevelCode = blackLevelCode_q;
  assign blankingLevelCode = blankingLevelCode_q;
  assign blackLevelMilli = blackLevelMilli_q;
  assign blankingLevelMilli = blankingLevelMilli_q;
endmodule
`default_nettype wire

// *** hdl/vpg_pkg.sv ***
// Package for the video encoder line-16 label, carrier phase and gain register slice.
// Assumes one 100 MHz clock and a byte-wide register port with 8-bit addresses.
`default_nettype none
package vpg_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int GAIN_W = 9;
  localparam int LEVEL_W = 6;
  localparam int CHROMA_W = 8;
  localparam int PROD_W = CHROMA_W + GAIN_W;
  localparam int MILLI_W = 16;
  localparam int PHASE_CDEG_W = 16;
  localparam int LABEL_BYTES = 5;
  localparam int LABEL_BITS = LABEL_BYTES * DATA_W;
  localparam int LABEL_IDX_W = 6;

  // Register offsets
  localparam logic [ADDR_W-1:0] OFS_LABEL_CTRL = 8'h54;
  localparam logic [ADDR_W-1:0] OFS_LABEL_A = 8'h55;
  localparam logic [ADDR_W-1:0] OFS_LABEL_B = 8'h56;
  localparam logic [ADDR_W-1:0] OFS_LABEL_C = 8'h57;
  localparam logic [ADDR_W-1:0] OFS_LABEL_D = 8'h58;
  localparam logic [ADDR_W-1:0] OFS_LABEL_E = 8'h59;
  localparam logic [ADDR_W-1:0] OFS_CARRIER_PHASE = 8'h5A;
  localparam logic [ADDR_W-1:0] OFS_BLUE_GAIN = 8'h5B;
  localparam logic [ADDR_W-1:0] OFS_RED_GAIN = 8'h5C;
  localparam logic [ADDR_W-1:0] OFS_BLUE_TOP_BLACK = 8'h5D;
  localparam logic [ADDR_W-1:0] OFS_RED_TOP_BLANK = 8'h5E;

  // Field positions
  localparam int POS_INSERT_ON = 7;
  localparam int POS_GAIN_TOP = 7;
  localparam int POS_FOLLOW_ON = 6;
  localparam int POS_LEVEL_HI = 5;

  // Reset values
  localparam logic [DATA_W-1:0] RST_BYTE = 8'h00;
  localparam logic [LEVEL_W-1:0] RST_BLACK = 6'h00;
  localparam logic [LEVEL_W-1:0] RST_BLANK = 6'h35;

  // Recommended software codes
  localparam logic [DATA_W-1:0] PHASE_PAL_PORTS = 8'h0F;
  localparam logic [DATA_W-1:0] PHASE_PAL_TABLE = 8'h3A;
  localparam logic [DATA_W-1:0] PHASE_NTSC_PORTS = 8'h35;
  localparam logic [DATA_W-1:0] PHASE_NTSC_TABLE = 8'h57;
  localparam logic [GAIN_W-1:0] BLUE_NOM_925 = 9'h076;
  localparam logic [GAIN_W-1:0] BLUE_NOM_100 = 9'h07D;
  localparam logic [GAIN_W-1:0] BLUE_NOM_SECAM = 9'h06A;
  localparam logic [GAIN_W-1:0] RED_NOM_925 = 9'h0A5;
  localparam logic [GAIN_W-1:0] RED_NOM_100 = 9'h0AF;
  localparam logic [GAIN_W-1:0] RED_NOM_SECAM = 9'h081;
  localparam logic [LEVEL_W-1:0] BLACK_REC_140 = 6'h3A;
  localparam logic [LEVEL_W-1:0] BLACK_REC_143 = 6'h33;

  // Level transfer in milli-IRE: slope per code step and offset
  localparam logic [MILLI_W-1:0] SLOPE_140 = 16'h013E;
  localparam logic [MILLI_W-1:0] SLOPE_143 = 16'h0144;
  localparam logic [MILLI_W-1:0] BLACK_OFS_140 = 16'h70E4;
  localparam logic [MILLI_W-1:0] BLACK_OFS_143 = 16'h6784;
  localparam logic [MILLI_W-1:0] BLANK_OFS_140 = 16'h6338;
  localparam logic [MILLI_W-1:0] BLANK_OFS_143 = 16'h652C;

  // One phase step is 360/256 degrees; kept as centi-degrees per 256 steps
  localparam logic [23:0] PHASE_FULL_CDEG = 24'h008CA0;
  localparam int PHASE_STEP_SHIFT = 8;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } vpg_bus_type;

  typedef struct packed {
    logic signed [CHROMA_W-1:0] cb;
    logic signed [CHROMA_W-1:0] cr;
    logic valid;
  } vpg_chroma_type;

  typedef struct packed {
    logic signed [PROD_W-1:0] u;
    logic signed [PROD_W-1:0] v;
    logic valid;
  } vpg_mod_type;

  typedef struct packed {
    logic strobe;
    logic fieldParity;
    logic phaseReset;
  } vpg_rtc_type;
endpackage
`default_nettype wire

// *** tb/vpg_regs_assertions.sv ***
// Checker for the register slice: gain and level fields, follow bits,
// carrier phase, label serialiser and chroma scaling.
// Assumes it is bound to vpg_regs and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module vpg_regs_checker
  import vpg_pkg::*;
(
  input wire logic clock, // Clock
  input wire logic nrst, // Reset, active low
  input wire vpg_pkg::vpg_bus_type bus, // Register request
  input wire logic labelWindow, // Label slot
  input wire logic labelBitTick, // Bit tick
  input wire logic labelBitValid, // Bit strobe
  input wire logic labelInsertOn, // Insertion enable
  input wire logic hsync, // Line sync
  input wire logic [vpg_pkg::DATA_W-1:0] carrierPhaseCode, // Phase code
  input wire logic [vpg_pkg::PHASE_CDEG_W-1:0] carrierPhaseCdeg, // Phase angle
  input wire logic carrierPhaseLoad, // Phase load
  input wire vpg_pkg::vpg_chroma_type chromaIn, // Samples in
  input wire vpg_pkg::vpg_mod_type chromaOut, // Samples out
  input wire logic [vpg_pkg::GAIN_W-1:0] blueDiffGainCode, // U gain
  input wire logic [vpg_pkg::GAIN_W-1:0] redDiffGainCode, // V gain
  input wire vpg_pkg::vpg_rtc_type rtcIn, // Control bits
  input wire logic fieldParity, // Field parity
  input wire logic fieldParityValid, // Parity follow
  input wire logic carrierPhaseReset, // Phase reset
  input wire logic [vpg_pkg::LEVEL_W-1:0] blackLevelCode, // Black code
  input wire logic [vpg_pkg::LEVEL_W-1:0] blankingLevelCode // Blank code
);
  default clocking clkDef @(posedge clock);
  endclocking
  default disable iff (!nrst);
  // Mirror of the phase reset follow bit, taken from bus writes
  logic phaseFollowSeen;
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      phaseFollowSeen <= 1'b0;
    end
    else if (bus.wr && bus.addr == OFS_RED_TOP_BLANK)
    begin
      phaseFollowSeen <= bus.wdata[POS_FOLLOW_ON];
    end
  end
  sequence s_phaseWr;
    bus.wr && bus.addr == OFS_CARRIER_PHASE;
  endsequence
  sequence s_phaseSettle;
    carrierPhaseCode == $past(bus.wdata) ##1
      carrierPhaseCdeg == 16'((24'($past(bus.wdata, 2)) * PHASE_FULL_CDEG) >> 8);
  endsequence
  property p_phase;
    s_phaseWr |=> s_phaseSettle;
  endproperty
  a_phase: assert property (p_phase) else $error("phase code or angle wrong");
  property p_blueLow;
    bus.wr && bus.addr == OFS_BLUE_GAIN |=> blueDiffGainCode[7:0] == $past(bus.wdata);
  endproperty
  a_blueLow: assert property (p_blueLow) else $error("blue gain low byte wrong");
  property p_blueTop;
    bus.wr && bus.addr == OFS_BLUE_TOP_BLACK |=> blueDiffGainCode[8] == $past(bus.wdata[7])
      && fieldParityValid == $past(bus.wdata[6]) && blackLevelCode == $past(bus.wdata[5:0]);
  endproperty
  a_blueTop: assert property (p_blueTop) else $error("0x5D fields wrong");
  property p_redLow;
    bus.wr && bus.addr == OFS_RED_GAIN |=> redDiffGainCode[7:0] == $past(bus.wdata);
  endproperty
  a_redLow: assert property (p_redLow) else $error("red gain low byte wrong");
  property p_redTop;
    bus.wr && bus.addr == OFS_RED_TOP_BLANK |=> redDiffGainCode[8] == $past(bus.wdata[7])
      && blankingLevelCode == $past(bus.wdata[5:0]);
  endproperty
  a_redTop: assert property (p_redTop) else $error("0x5E fields wrong");
  property p_parity;
    rtcIn.strobe && fieldParityValid |=> fieldParity == $past(rtcIn.fieldParity);
  endproperty
  a_parity: assert property (p_parity) else $error("field parity not followed");
  property p_parityHold;
    !(rtcIn.strobe && fieldParityValid) |=> $stable(fieldParity);
  endproperty
  a_parityHold: assert property (p_parityHold) else $error("field parity moved");
  property p_phaseReset;
    carrierPhaseReset == $past(phaseFollowSeen && rtcIn.strobe && rtcIn.phaseReset);
  endproperty
  a_phaseReset: assert property (p_phaseReset) else $error("stray phase reset");
  property p_label;
    labelBitValid |-> $past(labelWindow && labelInsertOn && labelBitTick);
  endproperty
  a_label: assert property (p_label) else $error("label bit without enable");
  property p_chroma;
    chromaIn.valid |=> chromaOut.u == $past(17'(chromaIn.cb) * 17'($signed(blueDiffGainCode)))
      && chromaOut.v == $past(17'(chromaIn.cr) * 17'($signed(redDiffGainCode)))
      && chromaOut.valid;
  endproperty
  a_chroma: assert property (p_chroma) else $error("chroma scaling wrong");
  property p_load;
    hsync |=> carrierPhaseLoad;
  endproperty
  a_load: assert property (p_load) else $error("phase load missing");
endmodule
bind vpg_regs vpg_regs_checker u_chk (.clock, .nrst, .bus, .labelWindow, .labelBitTick,
  .labelBitValid, .labelInsertOn, .hsync, .carrierPhaseCode, .carrierPhaseCdeg,
  .carrierPhaseLoad, .chromaIn, .chromaOut, .blueDiffGainCode, .redDiffGainCode, .rtcIn,
  .fieldParity, .fieldParityValid, .carrierPhaseReset, .blackLevelCode, .blankingLevelCode);
`default_nettype wire

// *** tb/tb.sv ***
// Self-checking bench for the register slice.
// Assumes vpg_regs and its package are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import vpg_pkg::*;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  vpg_bus_type bus = '0;
  logic labelWindow = 1'b0;
  logic labelBitTick = 1'b0;
  logic hsync = 1'b0;
  vpg_chroma_type chromaIn = '0;
  vpg_rtc_type rtcIn = '0;
  logic whiteToSync143 = 1'b0;
  logic [7:0] rdata;
  logic labelBit;
  logic labelBitValid;
  logic labelInsertOn;
  logic [7:0] carrierPhaseCode;
  logic [15:0] carrierPhaseCdeg;
  logic carrierPhaseLoad;
  vpg_mod_type chromaOut;
  logic [8:0] blueDiffGainCode;
  logic [8:0] redDiffGainCode;
  logic fieldParity;
  logic fieldParityValid;
  logic carrierPhaseReset;
  logic [5:0] blackLevelCode;
  logic [5:0] blankingLevelCode;
  logic [15:0] blackLevelMilli;
  logic [15:0] blankingLevelMilli;
  int errors = 0;
  int check_count = 0;

  vpg_regs dut (.clock, .nrst, .bus, .rdata, .labelWindow, .labelBitTick, .labelBit,
    .labelBitValid, .labelInsertOn, .hsync, .carrierPhaseCode, .carrierPhaseCdeg,
    .carrierPhaseLoad, .chromaIn, .chromaOut, .blueDiffGainCode, .redDiffGainCode, .rtcIn,
    .fieldParity, .fieldParityValid, .carrierPhaseReset, .whiteToSync143, .blackLevelCode,
    .blankingLevelCode, .blackLevelMilli, .blankingLevelMilli);

  always #5 clock = ~clock;

  task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      errors++;
      $display("[ERR] %s expected %h seen %h", name, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock);
    bus <= '0;
  endtask

  // Read data is looked at only in the cycle after the strobe
  task automatic rdChk(input logic [7:0] a, input logic [7:0] e);
    @(posedge clock);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clock);
    bus <= '0;
    #1;
    chk("rdata", 32'(e), 32'(rdata));
  endtask

  task automatic sample(input logic signed [7:0] c, input logic signed [7:0] r);
    @(posedge clock);
    chromaIn <= '{cb: c, cr: r, valid: 1'b1};
    @(posedge clock);
    chromaIn <= '0;
    #1;
  endtask

  task automatic rtc(input logic f, input logic p);
    @(posedge clock);
    rtcIn <= '{strobe: 1'b1, fieldParity: f, phaseReset: p};
    @(posedge clock);
    rtcIn <= '0;
    #1;
  endtask

  task automatic tResetVals();
    for (int i = 0; i < 11; i++)
      rdChk(8'h54 + 8'(i), (i == 10) ? 8'h35 : 8'h00);
    rdChk(8'h60, 8'h00);
  endtask

  task automatic tRegs();
    for (int i = 0; i < 10; i++)
      wr(8'h55 + 8'(i), 8'(i) ^ 8'hC3);
    for (int i = 0; i < 10; i++)
      rdChk(8'h55 + 8'(i), 8'(i) ^ 8'hC3);
    wr(8'h54, 8'hFF);
    rdChk(8'h54, 8'h80);
    chk("insertOn", 32'h1, 32'(labelInsertOn));
    wr(8'h54, 8'h00);
    wr(8'h60, 8'hFF);
    rdChk(8'h60, 8'h00);
  endtask

  task automatic tPhase();
    logic [7:0] codes [4] = '{8'h0F, 8'h3A, 8'h35, 8'h57};
    foreach (codes[i])
    begin
      wr(OFS_CARRIER_PHASE, codes[i]);
      repeat (2) @(posedge clock);
      #1;
      chk("phaseCode", 32'(codes[i]), 32'(carrierPhaseCode));
      chk("phaseCdeg", (32'(codes[i]) * 32'h8CA0) >> 8, 32'(carrierPhaseCdeg));
    end
    @(posedge clock);
    hsync <= 1'b1;
    @(posedge clock);
    hsync <= 1'b0;
    #1;
    chk("phaseLoad", 32'h1, 32'(carrierPhaseLoad));
  endtask

  task automatic tGain();
    wr(8'h5B, 8'h76);
    wr(8'h5D, 8'hC5);
    wr(8'h5C, 8'hA5);
    wr(8'h5E, 8'h6A);
    repeat (2) @(posedge clock);
    #1;
    chk("blueGain", 32'h176, 32'(blueDiffGainCode));
    chk("redGain", 32'h0A5, 32'(redDiffGainCode));
    chk("black", 32'h05, 32'(blackLevelCode));
    chk("blank", 32'h2A, 32'(blankingLevelCode));
    chk("blackMilli", 32'h771A, 32'(blackLevelMilli));
    chk("blankMilli", 32'h9764, 32'(blankingLevelMilli));
    @(posedge clock);
    whiteToSync143 <= 1'b1;
    repeat (2) @(posedge clock);
    #1;
    chk("blackMilli", 32'h6DD8, 32'(blackLevelMilli));
    chk("blankMilli", 32'h9A54, 32'(blankingLevelMilli));
    sample(8'sh0A, -8'sh02);
    chk("u", -32'sh564, 32'(chromaOut.u));
    chk("v", -32'sh14A, 32'(chromaOut.v));
    chk("chromaValid", 32'h1, 32'(chromaOut.valid));
    wr(8'h5B, 8'h00);
    wr(8'h5D, 8'h45);
    sample(8'sh64, 8'sh01);
    chk("uZero", 32'h0, 32'(chromaOut.u));
    chk("vNom", 32'h0A5, 32'(chromaOut.v));
  endtask

  task automatic tRtc();
    chk("followOn", 32'h1, 32'(fieldParityValid));
    rtc(1'b1, 1'b1);
    chk("parity", 32'h1, 32'(fieldParity));
    chk("phaseReset", 32'h1, 32'(carrierPhaseReset));
    @(posedge clock);
    #1;
    chk("phaseReset", 32'h0, 32'(carrierPhaseReset));
    wr(8'h5D, 8'h05);
    wr(8'h5E, 8'h2A);
    #1;
    chk("followOn", 32'h0, 32'(fieldParityValid));
    rtc(1'b0, 1'b1);
    chk("parity", 32'h1, 32'(fieldParity));
    chk("phaseReset", 32'h0, 32'(carrierPhaseReset));
  endtask

  task automatic tLabel();
    logic [39:0] bits = 40'hE5D4C3B2A1;
    for (int i = 0; i < 5; i++)
      wr(8'h55 + 8'(i), bits[8*i +: 8]);
    @(posedge clock);
    labelWindow <= 1'b1;
    labelBitTick <= 1'b1;
    repeat (3)
    begin
      @(posedge clock);
      #1;
      chk("labelOff", 32'h0, 32'(labelBitValid));
    end
    @(posedge clock);
    labelWindow <= 1'b0;
    labelBitTick <= 1'b0;
    wr(8'h54, 8'h80);
    @(posedge clock);
    labelWindow <= 1'b1;
    labelBitTick <= 1'b1;
    // Forty-one ticks back to back; the last one must be ignored
    for (int k = 0; k < 41; k++)
    begin
      @(posedge clock);
      if (k == 40)
        labelBitTick <= 1'b0;
      #1;
      chk("labelValid", (k < 40) ? 32'h1 : 32'h0, 32'(labelBitValid));
      if (k < 40)
        chk("labelBit", 32'(bits[k]), 32'(labelBit));
    end
    @(posedge clock);
    labelWindow <= 1'b0;
  endtask

  task automatic summarize();
    if (errors == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (10) @(posedge clock);
    nrst <= 1'b1;
    tResetVals();
    tRegs();
    tPhase();
    tGain();
    tRtc();
    tLabel();
    summarize();
  end
endmodule
`default_nettype wire
